// file: compact_alu_format_decoder.sv
`timescale 1ns/1ps
module compact_alu_format_decoder (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   output logic instrReady,
   output logic retired
);

   typedef struct packed {
      logic [7:0][31:0] loRegs;
      logic [3:0] flags;
      logic ctrlEn;
      logic unsup;
      logic [2:0] stallCnt;
      logic retired;
      logic instrReady;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic awReady;
      logic wReady;
      logic bValid;
      logic [1:0] bResp;
      logic arReady;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } state_s;

   typedef struct packed {
      logic ok;
      logic wr;
      logic [2:0] idx;
      logic [31:0] val;
      logic [3:0] flags;
      logic [2:0] cyc;
   } exec_s;

   state_s s_q;
   state_s s_d;

   // Returns {carry, overflow, sum} of a + b + cin.
   function automatic logic [33:0] addFlags(input logic [31:0] a, input logic [31:0] b,
                                            input logic cin);
      logic [32:0] s;
      logic v;
      s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
      v = (a[31] == b[31]) && (s[31] != a[31]);
      return {s[32], v, s[31:0]};
   endfunction : addFlags

   // Returns {carry, result}. An amount of zero leaves value and carry alone.
   function automatic logic [32:0] shifter(input logic [1:0] kind, input logic [31:0] val,
                                           input logic [7:0] amt, input logic cin);
      logic [32:0] t;
      logic [31:0] r;
      logic [4:0] rot;
      t = {cin, val};
      r = val;
      rot = amt[4:0];
      if (amt != 8'h0) begin
         case (kind)
            compact_alu_pkg::SH_LSL: begin
               if (amt <= 8'd32) begin
                  t = {1'b0, val} << amt;
               end else begin
                  t = 33'h0;
               end
            end
            compact_alu_pkg::SH_LSR: begin
               if (amt <= 8'd32) begin
                  t = {val, 1'b0} >> amt;
                  t = {t[0], t[32:1]};
               end else begin
                  t = 33'h0;
               end
            end
            compact_alu_pkg::SH_ASR: begin
               if (amt < 8'd32) begin
                  t = 33'($signed({val, 1'b0}) >>> amt);
                  t = {t[0], t[32:1]};
               end else begin
                  t = {val[31], {32{val[31]}}};
               end
            end
            default: begin
               r = (val >> rot) | (val << (6'd32 - {1'b0, rot}));
               t = {r[31], r};
            end
         endcase
      end
      return t;
   endfunction : shifter

   // Multiplier early termination on the destination operand, as the 32-bit form does.
   function automatic logic [2:0] mulCycles(input logic [31:0] m);
      logic [2:0] extra;
      if (m[31:8] == 24'h0 || m[31:8] == 24'hffffff) begin
         extra = 3'h1;
      end else if (m[31:16] == 16'h0 || m[31:16] == 16'hffff) begin
         extra = 3'h2;
      end else if (m[31:24] == 8'h0 || m[31:24] == 8'hff) begin
         extra = 3'h3;
      end else begin
         extra = 3'h4;
      end
      return compact_alu_pkg::CYC_MUL_BASE + extra;
   endfunction : mulCycles

   function automatic exec_s execute(input logic [15:0] ins, input logic [7:0][31:0] r,
                                     input logic [3:0] f);
      exec_s e;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] res;
      logic [33:0] ar;
      logic [32:0] sr;
      logic c;
      logic v;
      logic logical;
      logic [7:0] amt;
      c = f[compact_alu_pkg::FLAG_C];
      v = f[compact_alu_pkg::FLAG_V];
      e = '0;
      e.ok = 1'b1;
      e.wr = 1'b1;
      e.idx = ins[2:0];
      e.cyc = compact_alu_pkg::CYC_SIMPLE;
      logical = 1'b1;
      a = r[ins[2:0]];
      b = r[ins[5:3]];
      res = 32'h0;
      if (ins[15:11] == compact_alu_pkg::TAG_ADDSUB) begin
         a = r[ins[5:3]];
         b = ins[10] ? {29'h0, ins[8:6]} : r[ins[8:6]];
         ar = ins[9] ? addFlags(a, ~b, 1'b1) : addFlags(a, b, 1'b0);
         {c, v, res} = ar;
         logical = 1'b0;
      end else if (ins[15:13] == compact_alu_pkg::TAG_SHIFT) begin
         amt = {3'h0, ins[10:6]};
         if (amt == 8'h0 && ins[12:11] != compact_alu_pkg::SH_LSL) begin
            amt = 8'd32;
         end
         sr = shifter(ins[12:11], b, amt, c);
         {c, res} = sr;
      end else if (ins[15:13] == compact_alu_pkg::TAG_IMM8) begin
         e.idx = ins[10:8];
         a = r[ins[10:8]];
         b = {24'h0, ins[7:0]};
         case (ins[12:11])
            compact_alu_pkg::IMM_MOVE: res = b;
            compact_alu_pkg::IMM_ADD: begin
               {c, v, res} = addFlags(a, b, 1'b0);
               logical = 1'b0;
            end
            default: begin
               {c, v, res} = addFlags(a, ~b, 1'b1);
               logical = 1'b0;
               e.wr = (ins[12:11] != compact_alu_pkg::IMM_CMP);
            end
         endcase
      end else if (ins[15:10] == compact_alu_pkg::TAG_ALU) begin
         case (ins[9:6])
            compact_alu_pkg::ALU_AND: res = a & b;
            compact_alu_pkg::ALU_XOR: res = a ^ b;
            compact_alu_pkg::ALU_ORR: res = a | b;
            compact_alu_pkg::ALU_BIC: res = a & ~b;
            compact_alu_pkg::ALU_MVN: res = ~b;
            compact_alu_pkg::ALU_LSL, compact_alu_pkg::ALU_LSR, compact_alu_pkg::ALU_ASR,
            compact_alu_pkg::ALU_ROR: begin
               // The register-amount shift costs one internal cycle, so two in all.
               e.cyc = compact_alu_pkg::CYC_REG_SHIFT;
               if (ins[9:6] == compact_alu_pkg::ALU_ROR) begin
                  sr = shifter(compact_alu_pkg::SH_ROR, a, b[7:0], c);
               end else begin
                  sr = shifter(2'(ins[9:6] - compact_alu_pkg::ALU_LSL), a, b[7:0], c);
               end
               {c, res} = sr;
            end
            compact_alu_pkg::ALU_ADC: begin
               {c, v, res} = addFlags(a, b, c);
               logical = 1'b0;
            end
            compact_alu_pkg::ALU_SBC: begin
               {c, v, res} = addFlags(a, ~b, c);
               logical = 1'b0;
            end
            compact_alu_pkg::ALU_TST: begin
               res = a & b;
               e.wr = 1'b0;
            end
            compact_alu_pkg::ALU_NEG: begin
               {c, v, res} = addFlags(32'h0, ~b, 1'b1);
               logical = 1'b0;
            end
            compact_alu_pkg::ALU_CMP: begin
               {c, v, res} = addFlags(a, ~b, 1'b1);
               e.wr = 1'b0;
               logical = 1'b0;
            end
            compact_alu_pkg::ALU_CMN: begin
               {c, v, res} = addFlags(a, b, 1'b0);
               e.wr = 1'b0;
               logical = 1'b0;
            end
            default: begin
               // Carry and overflow are left unchanged by the product.
               res = b * a;
               e.cyc = mulCycles(a);
            end
         endcase
      end else begin
         e.ok = 1'b0;
         e.wr = 1'b0;
      end
      if (logical) begin
         v = f[compact_alu_pkg::FLAG_V];
      end
      e.val = res;
      e.flags[compact_alu_pkg::FLAG_N] = res[31];
      e.flags[compact_alu_pkg::FLAG_Z] = (res == 32'h0);
      e.flags[compact_alu_pkg::FLAG_C] = c;
      e.flags[compact_alu_pkg::FLAG_V] = v;
      return e;
   endfunction : execute

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[8*i +: 8] = data[8*i +: 8];
         end
      end
      return m;
   endfunction : mergeBytes

   always_comb begin
      exec_s e;
      logic [31:0] word;
      e = execute(instrWord, s_q.loRegs, s_q.flags);
      word = 32'h0;
      s_d = s_q;
      s_d.retired = 1'b0;

      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end
      if (s_q.awReady && s_axi_awvalid) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_q.wReady && s_axi_wvalid) begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      // Address and data may arrive in either order; the write lands once both are held.
      if (s_d.awHeld && s_d.wHeld && !s_d.bValid) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = compact_alu_pkg::RESP_OKAY;
         if (s_d.awAddr[7:5] == compact_alu_pkg::LOREG_PAGE) begin
            s_d.loRegs[s_d.awAddr[4:2]] =
               mergeBytes(s_q.loRegs[s_d.awAddr[4:2]], s_d.wData, s_d.wStrb);
         end else if ({s_d.awAddr[7:2], 2'h0} == compact_alu_pkg::ADDR_FLAGS) begin
            if (s_d.wStrb[0]) begin
               s_d.flags = s_d.wData[3:0];
            end
         end else if ({s_d.awAddr[7:2], 2'h0} == compact_alu_pkg::ADDR_STATUS) begin
            if (s_d.wStrb[0] && s_d.wData[compact_alu_pkg::STAT_UNSUP]) begin
               s_d.unsup = 1'b0;
            end
         end else if ({s_d.awAddr[7:2], 2'h0} == compact_alu_pkg::ADDR_CTRL) begin
            if (s_d.wStrb[0]) begin
               s_d.ctrlEn = s_d.wData[compact_alu_pkg::CTRL_EN];
            end
         end else begin
            s_d.bResp = compact_alu_pkg::RESP_SLVERR;
         end
      end

      if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
      if (s_q.arReady && s_axi_arvalid) begin
         s_d.rValid = 1'b1;
         s_d.rResp = compact_alu_pkg::RESP_OKAY;
         if (s_axi_araddr[7:5] == compact_alu_pkg::LOREG_PAGE) begin
            word = s_q.loRegs[s_axi_araddr[4:2]];
         end else if ({s_axi_araddr[7:2], 2'h0} == compact_alu_pkg::ADDR_FLAGS) begin
            word = {28'h0, s_q.flags};
         end else if ({s_axi_araddr[7:2], 2'h0} == compact_alu_pkg::ADDR_STATUS) begin
            word[compact_alu_pkg::STAT_BUSY] = (s_q.stallCnt != 3'h0);
            word[compact_alu_pkg::STAT_UNSUP] = s_q.unsup;
         end else if ({s_axi_araddr[7:2], 2'h0} == compact_alu_pkg::ADDR_CTRL) begin
            word[compact_alu_pkg::CTRL_EN] = s_q.ctrlEn;
         end else begin
            s_d.rResp = compact_alu_pkg::RESP_SLVERR;
         end
         s_d.rData = word;
      end

      // The result commits at the accepting edge, then the port stalls for the rest of the
      // instruction's cycles. Committing after the bus write lets hardware win a collision.
      if (s_q.stallCnt != 3'h0) begin
         s_d.stallCnt = s_q.stallCnt - 3'h1;
      end
      if (s_q.instrReady && instrValid) begin
         if (e.ok) begin
            if (e.wr) begin
               s_d.loRegs[e.idx] = e.val;
            end
            s_d.flags = e.flags;
            s_d.stallCnt = e.cyc - 3'h1;
            s_d.retired = 1'b1;
         end else begin
            s_d.unsup = 1'b1;
         end
      end

      s_d.awReady = !s_d.awHeld && !s_d.bValid;
      s_d.wReady = !s_d.wHeld && !s_d.bValid;
      s_d.arReady = !s_d.rValid;
      s_d.instrReady = s_d.ctrlEn && (s_d.stallCnt == 3'h0);
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.ctrlEn <= compact_alu_pkg::CTRL_EN_RST;
         s_q.flags <= compact_alu_pkg::FLAGS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = s_q.awReady;
   assign s_axi_wready = s_q.wReady;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_arready = s_q.arReady;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
   assign s_axi_rvalid = s_q.rValid;
   assign instrReady = s_q.instrReady;
   assign retired = s_q.retired;

endmodule : compact_alu_format_decoder

// file: compact_alu_format_decoder_chk.sv
`timescale 1ns/1ps
module compact_alu_format_decoder_chk (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic instrReady,
   input wire logic retired
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   logic take;
   logic known;
   logic good;
   logic regSh;
   logic isMul;
   assign take = instrValid && instrReady;
   assign known = instrWord[15:14] == 2'h0 && !instrWord[13] || instrWord[15:13] == 3'h1
      || instrWord[15:10] == 6'h10;
   assign good = take && known;
   assign regSh = instrWord[15:10] == 6'h10 && instrWord[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7};
   assign isMul = instrWord[15:10] == 6'h10 && instrWord[9:6] == 4'hd;

   // A register-driven shift holds the port off for exactly one extra cycle.
   sequence sOneStall;
      !instrReady ##1 instrReady;
   endsequence
   sequence sMulStall;
      !instrReady ##[1:4] instrReady;
   endsequence

   a_retire_after: assert property (good |=> retired)
      else $error("retire pulse missing after a taken instruction");
   a_retire_cause: assert property (retired |-> $past(good))
      else $error("retire pulse without a taken instruction");
   a_shift_stall: assert property (good && regSh |=> sOneStall)
      else $error("register shift spacing wrong");
   a_mul_stall: assert property (good && isMul |=> sMulStall)
      else $error("product spacing wrong");
   a_plain_ready: assert property (take && !regSh && !isMul |=> instrReady)
      else $error("single cycle instruction stalled");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_write_busy: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
      else $error("write channel open during response");
   a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready)
      else $error("write response not retired");
endmodule : compact_alu_format_decoder_chk

bind compact_alu_format_decoder compact_alu_format_decoder_chk u_chk (
   .ref_clk, .nrst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .instrValid, .instrWord, .instrReady,
   .retired
);

// file: compact_alu_format_decoder_tb.sv
`timescale 1ns/1ps
module compact_alu_format_decoder_tb;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go = 1'b0;
   logic [15:0] word = 16'h0, instrWord;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic instrValid, instrReady, retired;
   int err_total = 0, n_tests = 0, cyc = 0;

   compact_alu_format_decoder DUT (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instrValid, .instrWord, .instrReady,
      .retired);
   instr_feed FEED (.ref_clk, .nrst, .go, .word, .instrReady, .instrValid, .instrWord);

   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3) begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask : axiWr

   task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3) begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : axiRd

   function automatic logic [7:0] regA(input logic [2:0] i);
      return compact_alu_pkg::ADDR_LOREG_BASE + {3'h0, i, 2'h0};
   endfunction : regA

   task automatic wrReg(input logic [2:0] i, input logic [31:0] d);
      logic [1:0] r;
      axiWr(regA(i), d, r);
   endtask : wrReg

   task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axiRd(a, d, r);
      chk(nm, e, d);
   endtask : rdChk

   // Codes 0 to 15 follow the two-register table; 16 add, 17 subtract, 18 move immediate.
   // The entry carry flag is always 1 and overflow 0, as every operation below sets them so.
   function automatic logic [36:0] aluRef(input logic [4:0] f, input logic [31:0] d, s);
      logic [32:0] t;
      logic [31:0] r, x, y;
      logic c, v, w, ln;
      c = 1'b1;
      v = 1'b0;
      ln = 1'b1;
      w = !(f inside {5'h08, 5'h0a, 5'h0b});
      case (f)
         5'h00, 5'h08: r = d & s;
         5'h01: r = d ^ s;
         5'h02: {c, r} = {1'b0, d} << s[7:0];
         5'h03: {r, c} = {d, 1'b0} >> s[7:0];
         5'h04: {r, c} = $signed({d, 1'b0}) >>> s[7:0];
         5'h07: {r, c} = 33'({d, d, 1'b0} >> s[7:0]);
         5'h0c: r = d | s;
         5'h0d: r = d * s;
         5'h0e: r = d & ~s;
         5'h0f: r = ~s;
         5'h12: r = s;
         default: ln = 1'b0;
      endcase
      if (!ln) begin
         x = (f == 5'h09) ? 32'h0 : d;
         y = (f inside {5'h06, 5'h09, 5'h0a, 5'h11}) ? ~s : s;
         t = {1'b0, x} + {1'b0, y} + 33'(f inside {5'h05, 5'h06, 5'h09, 5'h0a, 5'h11});
         r = t[31:0];
         c = t[32];
         v = (x[31] == y[31]) && (r[31] != x[31]);
      end
      return {w, r[31], r == 32'h0, c, v, r};
   endfunction : aluRef

   task automatic exe(input logic [15:0] w, input logic sup);
      int n;
      go <= 1'b1;
      word <= w;
      @(posedge ref_clk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (instrValid !== 1'b0 && n < 20);
      chk("retired", {31'h0, sup}, {31'h0, retired});
   endtask : exe

   task automatic doOp(input logic [15:0] w, input logic [2:0] dst, a, b,
                       input logic [31:0] av, bv, input logic [4:0] f);
      logic [36:0] e;
      logic [1:0] r;
      e = aluRef(f, av, bv);
      wrReg(b, bv);
      wrReg(a, av);
      axiWr(compact_alu_pkg::ADDR_FLAGS, 32'h2, r);
      exe(w, 1'b1);
      rdChk("result", regA(dst), e[36] ? e[31:0] : av);
      rdChk("flags", compact_alu_pkg::ADDR_FLAGS, {28'h0, e[35:32]});
   endtask : doOp

   task automatic t_map();
      logic [31:0] d;
      logic [1:0] r;
      rdChk("ctrl", compact_alu_pkg::ADDR_CTRL, {31'h0, compact_alu_pkg::CTRL_EN_RST});
      rdChk("flags", compact_alu_pkg::ADDR_FLAGS, {28'h0, compact_alu_pkg::FLAGS_RST});
      axiRd(8'h3c, d, r);
      chk("rd resp", {30'h0, compact_alu_pkg::RESP_SLVERR}, {30'h0, r});
      chk("rd data", 32'h0, d);
      axiWr(8'h3c, 32'h1, r);
      chk("wr resp", {30'h0, compact_alu_pkg::RESP_SLVERR}, {30'h0, r});
      s_axi_wstrb <= 4'h1;
      wrReg(3'h3, 32'hffff_ffff);
      s_axi_wstrb <= 4'hf;
      rdChk("strobe", regA(3'h3), 32'h0000_00ff);
   endtask : t_map

   task automatic t_formats();
      logic [4:0] fc[4] = '{5'h12, 5'h0a, 5'h10, 5'h11};
      for (int k = 0; k < 3; k++) begin
         doOp({3'h0, k[1:0], 5'h1b, 6'h2a}, 3'h2, 3'h5, 3'h7,
              32'h8000_00f1, 32'h1b, 5'(k + 2));
      end
      for (int i = 0; i < 4; i++) begin
         doOp({5'h03, i[0], i[1], 9'h198}, 3'h0, 3'h3,
              i[0] ? 3'h7 : 3'h6, 32'h7fff_fffe, i[0] ? 32'h6 : 32'h9, {4'h8, i[1]});
      end
      // The register value makes the byte add overflow, so its overflow flag is exercised.
      for (int k = 0; k < 4; k++) begin
         doOp({3'h1, k[1:0], 11'h491}, 3'h4, 3'h4, 3'h7,
              32'h7fff_ff80, 32'h91, fc[k]);
      end
      for (int f = 0; f < 16; f++) begin
         doOp(
              {6'h10, f[3:0], 6'h11}, 3'h1, 3'h1, 3'h2, 32'h8000_0f0f, 32'h4, {1'b0, f[3:0]});
      end
   endtask : t_formats

   // Pairs go back to back; the spacing of the two retire pulses is the cost of the first.
   task automatic t_gap();
      logic [15:0] ws[6] = '{16'h4091, 16'h41d1, 16'h4351, 16'h4351, 16'h4351, 16'h2001};
      logic [31:0] vs[6] = '{32'h0, 32'h0, 32'h10, 32'h1234, 32'h8000_0000, 32'h0};
      int gs[6] = '{2, 2, 2, 3, 5, 1};
      int n, m;
      for (int i = 0; i < 6; i++) begin
         wrReg(3'h1, vs[i]);
         go <= 1'b1;
         word <= ws[i];
         @(posedge ref_clk);
         word <= 16'h2001;
         @(posedge ref_clk);
         go <= 1'b0;
         n = 0;
         m = 0;
         while (m < 2 && n < 40) begin
            @(posedge ref_clk);
            n++;
            if (retired === 1'b1) begin
               m++;
               if (m == 1) n = 0;
            end
         end
         chk("gap", gs[i], n);
      end
   endtask : t_gap

   task automatic t_bad();
      logic [1:0] r;
      exe(16'he000, 1'b0);
      rdChk("sticky", compact_alu_pkg::ADDR_STATUS, 32'h2);
      axiWr(compact_alu_pkg::ADDR_STATUS, 32'h2, r);
      rdChk("cleared", compact_alu_pkg::ADDR_STATUS, 32'h0);
      axiWr(compact_alu_pkg::ADDR_CTRL, 32'h0, r);
      chk("ready off", 32'h0, {31'h0, instrReady});
      axiWr(compact_alu_pkg::ADDR_CTRL, 32'h1, r);
      rdChk("ctrl on", compact_alu_pkg::ADDR_CTRL, 32'h1);
   endtask : t_bad

   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      t_map();
      t_formats();
      t_gap();
      t_bad();
      end_sim();
   end
endmodule : compact_alu_format_decoder_tb

// file: compact_alu_pkg.sv
package compact_alu_pkg;

   // Register map on the AXI4-Lite slave, byte addresses.
   localparam logic [7:0] ADDR_LOREG_BASE = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_CTRL = 8'h28;
   localparam logic [2:0] LOREG_PAGE = 3'h0;

   // Condition flag positions inside the program_status_word view.
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;
   localparam int STAT_BUSY = 0;
   localparam int STAT_UNSUP = 1;
   localparam int CTRL_EN = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [3:0] FLAGS_RST = 4'h0;

   // Format recognition patterns.
   localparam logic [2:0] TAG_SHIFT = 3'h0;
   localparam logic [4:0] TAG_ADDSUB = 5'h03;
   localparam logic [2:0] TAG_IMM8 = 3'h1;
   localparam logic [5:0] TAG_ALU = 6'h10;

   // Shifter kinds; the shift format uses the same codes in bits 12 to 11.
   localparam logic [1:0] SH_LSL = 2'h0;
   localparam logic [1:0] SH_LSR = 2'h1;
   localparam logic [1:0] SH_ASR = 2'h2;
   localparam logic [1:0] SH_ROR = 2'h3;

   // Byte-immediate function codes.
   localparam logic [1:0] IMM_MOVE = 2'h0;
   localparam logic [1:0] IMM_CMP = 2'h1;
   localparam logic [1:0] IMM_ADD = 2'h2;
   localparam logic [1:0] IMM_SUB = 2'h3;

   // Two-register function codes.
   localparam logic [3:0] ALU_AND = 4'h0;
   localparam logic [3:0] ALU_XOR = 4'h1;
   localparam logic [3:0] ALU_LSL = 4'h2;
   localparam logic [3:0] ALU_LSR = 4'h3;
   localparam logic [3:0] ALU_ASR = 4'h4;
   localparam logic [3:0] ALU_ADC = 4'h5;
   localparam logic [3:0] ALU_SBC = 4'h6;
   localparam logic [3:0] ALU_ROR = 4'h7;
   localparam logic [3:0] ALU_TST = 4'h8;
   localparam logic [3:0] ALU_NEG = 4'h9;
   localparam logic [3:0] ALU_CMP = 4'ha;
   localparam logic [3:0] ALU_CMN = 4'hb;
   localparam logic [3:0] ALU_ORR = 4'hc;
   localparam logic [3:0] ALU_MUL = 4'hd;
   localparam logic [3:0] ALU_BIC = 4'he;
   localparam logic [3:0] ALU_MVN = 4'hf;

   // Cycle counts of the equivalent 32-bit instructions.
   localparam logic [2:0] CYC_SIMPLE = 3'h1;
   localparam logic [2:0] CYC_REG_SHIFT = 3'h2;
   localparam logic [2:0] CYC_MUL_BASE = 3'h1;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : compact_alu_pkg

// file: instr_feed.sv
`timescale 1ns/1ps
module instr_feed (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic [15:0] word,
   input wire logic instrReady,
   output logic instrValid,
   output logic [15:0] instrWord
);
   // An idle word bus toggles each cycle so that a stale value is never mistaken for a request.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         instrValid <= 1'b0;
         instrWord <= 16'h0;
      end else if (!instrValid || instrReady) begin
         instrValid <= go;
         instrWord <= go ? word : ~instrWord;
      end
   end
endmodule : instr_feed
